// ---- tcc_params.svh ----
// Constants for the capture/compare channel block: register indices,
// field positions, reset values and counter limits.
// Assumes inclusion by bare name; byte address is four times the index.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register indices (byte address = index * 4)
`define TCC_IDX_CH0_LO   10'h0da
`define TCC_IDX_CH0_HI   10'h0db
`define TCC_IDX_CH1_LO   10'h0dc
`define TCC_IDX_CH1_HI   10'h0dd
`define TCC_IDX_CH2_LO   10'h0de
`define TCC_IDX_CH2_HI   10'h0df
`define TCC_IDX_CNT_LO   10'h0e2
`define TCC_IDX_CNT_HI   10'h0e3
`define TCC_IDX_CNT_CTL  10'h0e4
`define TCC_IDX_CTL1     10'h0e6
`define TCC_IDX_CTL2     10'h0e7
`define TCC_IDX_IRQ_ST   10'h0e8
`define TCC_IDX_IRQ_MASK 10'h0e9

// Counter control fields
`define TCC_CC_MODE_LSB  0
`define TCC_CC_CH1F_POS  6
`define TCC_CC_CH2F_POS  7

// Channel control fields
`define TCC_CTL_RSVD_POS 7
`define TCC_CTL_IM_POS   6
`define TCC_CTL_ACT_LSB  3
`define TCC_CTL_SEL_POS  2
`define TCC_CTL_CAP_LSB  0

// Reset values
`define TCC_CTL_RST      8'h40
`define TCC_VAL_RST      16'h0000
`define TCC_MASK_RST     2'h0

// Counter limits
`define TCC_CNT_TOP      16'hffff
`define TCC_CNT_ZERO     16'h0000
`define TCC_CNT_ONE      16'h0001

`endif

// ---- tcc_pkg.sv ----
// Types shared by the capture/compare channel block.
// Assumes nothing beyond a SystemVerilog compiler.
package tcc_pkg;

	typedef enum logic [1:0] {
		tcc_cnt_stop = 2'h0,
		tcc_cnt_free = 2'h1,
		tcc_cnt_mod  = 2'h2,
		tcc_cnt_updn = 2'h3
	} tcc_cnt_mode_t;

	typedef enum logic [2:0] {
		tcc_act_set      = 3'h0,
		tcc_act_clr      = 3'h1,
		tcc_act_tgl      = 3'h2,
		tcc_act_set_up   = 3'h3,
		tcc_act_clr_up   = 3'h4,
		tcc_act_clr0_set = 3'h5,
		tcc_act_set0_clr = 3'h6,
		tcc_act_none     = 3'h7
	} tcc_act_t;

	typedef enum logic [1:0] {
		tcc_cap_off  = 2'h0,
		tcc_cap_rise = 2'h1,
		tcc_cap_fall = 2'h2,
		tcc_cap_both = 2'h3
	} tcc_cap_t;

	typedef struct packed {
		logic     rsvd;
		logic     im;
		tcc_act_t act;
		logic     sel;
		tcc_cap_t cap;
	} tcc_ctl_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} tcc_sync_st_t;

	typedef struct packed {
		logic out;
		logic prev;
	} tcc_chan_st_t;

	typedef struct packed {
		logic [15:0]   ch0_val;
		logic [15:0]   ch1_val;
		logic [15:0]   ch2_val;
		tcc_ctl_t      ctl1;
		tcc_ctl_t      ctl2;
		tcc_cnt_mode_t mode;
		logic [1:0]    flags;
		logic [15:0]   cnt;
		logic          up;
		logic [1:0]    irq_st;
		logic [1:0]    irq_mask;
		logic [31:0]   prdata;
	} tcc_regs_t;

endpackage

// ---- tcc_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level on din.
`timescale 1ns/1ns
`default_nettype none
module tcc_sync
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Level
	input  wire logic din,
	output logic      lvl
);
	tcc_sync_st_t st_ff;
	tcc_sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// Accept a change once stages two and three agree
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.lvl = st_ff.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign lvl = st_ff.lvl;
endmodule
`default_nettype wire

// ---- tcc_chan.sv ----
// One capture/compare channel: output action on match, edge capture.
// Assumes a synchronised capture level and the shared counter state.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module tcc_chan
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// Configuration
	input  wire tcc_ctl_t    ctl,
	input  wire logic [15:0] own_val,
	input  wire logic [15:0] ch0_val,
	// Counter state
	input  wire logic [15:0] cnt,
	input  wire logic        tick,
	input  wire logic        count_up,
	input  wire logic        updown,
	// Pins
	input  wire logic        cap_lvl,
	output logic             cmp_out,
	// Events
	output logic             cap_stb,
	output logic             evt
);
	tcc_chan_st_t st_ff;
	tcc_chan_st_t nxt_st;
	logic         rise;
	logic         fall;
	logic         match;
	logic         match0;
	logic         zero;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.prev = cap_lvl;
		rise        = cap_lvl & ~st_ff.prev;
		fall        = ~cap_lvl & st_ff.prev;
		match       = tick & (cnt == own_val);
		match0      = tick & (cnt == ch0_val);
		zero        = tick & (cnt == `TCC_CNT_ZERO);
		// Edge select applies in capture mode only
		cap_stb = ~ctl.sel & ((ctl.cap[0] & rise) | (ctl.cap[1] & fall));
		evt     = cap_stb | (ctl.sel & match);
		if (ctl.sel) begin
			unique case (ctl.act)
				tcc_act_set: begin
					if (match) nxt_st.out = 1'b1;
				end
				tcc_act_clr: begin
					if (match) nxt_st.out = 1'b0;
				end
				tcc_act_tgl: begin
					if (match) nxt_st.out = ~st_ff.out;
				end
				tcc_act_set_up: begin
					if (match & count_up) begin
						nxt_st.out = 1'b1;
					end else if (updown ? (match & ~count_up) : zero) begin
						nxt_st.out = 1'b0;
					end
				end
				tcc_act_clr_up: begin
					if (match & count_up) begin
						nxt_st.out = 1'b0;
					end else if (updown ? (match & ~count_up) : zero) begin
						nxt_st.out = 1'b1;
					end
				end
				tcc_act_clr0_set: begin
					if (match) begin
						nxt_st.out = 1'b1;
					end else if (match0) begin
						nxt_st.out = 1'b0;
					end
				end
				tcc_act_set0_clr: begin
					if (match) begin
						nxt_st.out = 1'b0;
					end else if (match0) begin
						nxt_st.out = 1'b1;
					end
				end
				tcc_act_none: begin
					nxt_st.out = st_ff.out;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign cmp_out = st_ff.out;
endmodule
`default_nettype wire

// ---- tcc_top.sv ----
// Capture/compare channels 1 and 2 with shared counter and APB slave.
// Assumes an APB3 master on pclk and asynchronous capture pins.
//
// Function
// - Control bit 6 at one lets the channel event set its interrupt status; resets to one.
// - Control bits 5:3 select output action on compare; reset 000.
// - Action 000 sets, 001 clears, 010 toggles output on match.
// - Action 011 sets on up match, clears at zero or down match.
// - Action 100 clears on up match, sets at zero or down match.
// - Action 101 clears at channel 0 value, sets at own value.
// - Action 110 sets at channel 0 value, clears at own; 111 unused.
// - Control bit 2 selects capture (0) or compare (1); resets 0.
// - Control bits 1:0 select capture edge: none, rise, fall, both.
// - Each channel value is 16 bits, read/written as two bytes.
// - Counter modes: stopped, free-running, modulo, up/down to channel 0.
// - Channel flag set by event, cleared by writing 0, 1 no effect.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module tcc_top
	import tcc_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Channel pins
	input  wire logic        ch1_cap_in,
	input  wire logic        ch2_cap_in,
	output logic             ch1_cmp_out,
	output logic             ch2_cmp_out,
	// Interrupt
	output logic             irq
);
	tcc_regs_t   st_ff;
	tcc_regs_t   nxt_st;
	logic [9:0]  idx;
	logic        wr;
	logic        rd_setup;
	logic        tick;
	logic        updown;
	logic        ch1_lvl;
	logic        ch2_lvl;
	logic        ch1_cap;
	logic        ch2_cap;
	logic        ch1_evt;
	logic        ch2_evt;
	logic [1:0]  evt;
	logic [1:0]  req;

	// Replace one byte of a 16-bit value
	function automatic logic [15:0] put_byte(input logic [15:0] v,
			input logic hi, input logic [7:0] b);
		put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
	endfunction

	// Mapped register index
	function automatic logic is_mapped(input logic [9:0] i);
		case (i)
			`TCC_IDX_CH0_LO, `TCC_IDX_CH0_HI,
			`TCC_IDX_CH1_LO, `TCC_IDX_CH1_HI,
			`TCC_IDX_CH2_LO, `TCC_IDX_CH2_HI,
			`TCC_IDX_CNT_LO, `TCC_IDX_CNT_HI,
			`TCC_IDX_CNT_CTL, `TCC_IDX_CTL1, `TCC_IDX_CTL2,
			`TCC_IDX_IRQ_ST, `TCC_IDX_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	assign idx      = paddr[11:2];
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign tick     = (st_ff.mode != tcc_cnt_stop);
	assign updown   = (st_ff.mode == tcc_cnt_updn);
	assign evt      = {ch2_evt, ch1_evt};
	assign req      = evt & {st_ff.ctl2.im, st_ff.ctl1.im};

	tcc_sync u_sync1 (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.din     (ch1_cap_in),
		.lvl     (ch1_lvl)
	);

	tcc_sync u_sync2 (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.din     (ch2_cap_in),
		.lvl     (ch2_lvl)
	);

	tcc_chan u_chan1 (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.ctl      (st_ff.ctl1),
		.own_val  (st_ff.ch1_val),
		.ch0_val  (st_ff.ch0_val),
		.cnt      (st_ff.cnt),
		.tick     (tick),
		.count_up (st_ff.up),
		.updown   (updown),
		.cap_lvl  (ch1_lvl),
		.cmp_out  (ch1_cmp_out),
		.cap_stb  (ch1_cap),
		.evt      (ch1_evt)
	);

	tcc_chan u_chan2 (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.ctl      (st_ff.ctl2),
		.own_val  (st_ff.ch2_val),
		.ch0_val  (st_ff.ch0_val),
		.cnt      (st_ff.cnt),
		.tick     (tick),
		.count_up (st_ff.up),
		.updown   (updown),
		.cap_lvl  (ch2_lvl),
		.cmp_out  (ch2_cmp_out),
		.cap_stb  (ch2_cap),
		.evt      (ch2_evt)
	);

	always_comb begin
		nxt_st = st_ff;

		// Shared counter
		unique case (st_ff.mode)
			tcc_cnt_stop: begin
				nxt_st.up = 1'b1;
			end
			tcc_cnt_free: begin
				nxt_st.up  = 1'b1;
				nxt_st.cnt = (st_ff.cnt == `TCC_CNT_TOP) ? `TCC_CNT_ZERO
					: st_ff.cnt + `TCC_CNT_ONE;
			end
			tcc_cnt_mod: begin
				nxt_st.up  = 1'b1;
				nxt_st.cnt = (st_ff.cnt >= st_ff.ch0_val) ? `TCC_CNT_ZERO
					: st_ff.cnt + `TCC_CNT_ONE;
			end
			tcc_cnt_updn: begin
				if (st_ff.up) begin
					if (st_ff.cnt >= st_ff.ch0_val) begin
						nxt_st.up  = 1'b0;
						nxt_st.cnt = (st_ff.cnt == `TCC_CNT_ZERO) ? `TCC_CNT_ZERO
							: st_ff.cnt - `TCC_CNT_ONE;
					end else begin
						nxt_st.cnt = st_ff.cnt + `TCC_CNT_ONE;
					end
				end else begin
					if (st_ff.cnt == `TCC_CNT_ZERO) begin
						nxt_st.up  = 1'b1;
						nxt_st.cnt = (st_ff.ch0_val == `TCC_CNT_ZERO) ? `TCC_CNT_ZERO
							: `TCC_CNT_ONE;
					end else begin
						nxt_st.cnt = st_ff.cnt - `TCC_CNT_ONE;
					end
				end
			end
		endcase

		// Register writes at the access edge
		if (wr) begin
			unique case (idx)
				`TCC_IDX_CH0_LO: nxt_st.ch0_val = put_byte(st_ff.ch0_val, 1'b0, pwdata[7:0]);
				`TCC_IDX_CH0_HI: nxt_st.ch0_val = put_byte(st_ff.ch0_val, 1'b1, pwdata[7:0]);
				`TCC_IDX_CH1_LO: nxt_st.ch1_val = put_byte(st_ff.ch1_val, 1'b0, pwdata[7:0]);
				`TCC_IDX_CH1_HI: nxt_st.ch1_val = put_byte(st_ff.ch1_val, 1'b1, pwdata[7:0]);
				`TCC_IDX_CH2_LO: nxt_st.ch2_val = put_byte(st_ff.ch2_val, 1'b0, pwdata[7:0]);
				`TCC_IDX_CH2_HI: nxt_st.ch2_val = put_byte(st_ff.ch2_val, 1'b1, pwdata[7:0]);
				`TCC_IDX_CNT_LO: nxt_st.cnt = put_byte(st_ff.cnt, 1'b0, pwdata[7:0]);
				`TCC_IDX_CNT_HI: nxt_st.cnt = put_byte(st_ff.cnt, 1'b1, pwdata[7:0]);
				`TCC_IDX_CNT_CTL: begin
					nxt_st.mode  = tcc_cnt_mode_t'(pwdata[`TCC_CC_MODE_LSB +: 2]);
					nxt_st.flags = st_ff.flags & {pwdata[`TCC_CC_CH2F_POS],
						pwdata[`TCC_CC_CH1F_POS]};
				end
				`TCC_IDX_CTL1: nxt_st.ctl1 = tcc_ctl_t'(pwdata[7:0]);
				`TCC_IDX_CTL2: nxt_st.ctl2 = tcc_ctl_t'(pwdata[7:0]);
				`TCC_IDX_IRQ_ST: nxt_st.irq_st = st_ff.irq_st & ~pwdata[1:0];
				`TCC_IDX_IRQ_MASK: nxt_st.irq_mask = pwdata[1:0];
				default: nxt_st.irq_mask = st_ff.irq_mask;
			endcase
		end

		// Capture overrides a write in the same cycle
		if (ch1_cap) nxt_st.ch1_val = st_ff.cnt;
		if (ch2_cap) nxt_st.ch2_val = st_ff.cnt;

		// Set wins over clear
		nxt_st.flags  = nxt_st.flags | evt;
		nxt_st.irq_st = nxt_st.irq_st | req;

		// Read data sampled in the setup cycle
		if (rd_setup) begin
			unique case (idx)
				`TCC_IDX_CH0_LO: nxt_st.prdata = {24'h000000, st_ff.ch0_val[7:0]};
				`TCC_IDX_CH0_HI: nxt_st.prdata = {24'h000000, st_ff.ch0_val[15:8]};
				`TCC_IDX_CH1_LO: nxt_st.prdata = {24'h000000, st_ff.ch1_val[7:0]};
				`TCC_IDX_CH1_HI: nxt_st.prdata = {24'h000000, st_ff.ch1_val[15:8]};
				`TCC_IDX_CH2_LO: nxt_st.prdata = {24'h000000, st_ff.ch2_val[7:0]};
				`TCC_IDX_CH2_HI: nxt_st.prdata = {24'h000000, st_ff.ch2_val[15:8]};
				`TCC_IDX_CNT_LO: nxt_st.prdata = {24'h000000, st_ff.cnt[7:0]};
				`TCC_IDX_CNT_HI: nxt_st.prdata = {24'h000000, st_ff.cnt[15:8]};
				`TCC_IDX_CNT_CTL: nxt_st.prdata = {24'h000000, st_ff.flags, 4'h0,
					st_ff.mode};
				`TCC_IDX_CTL1: nxt_st.prdata = {24'h000000, st_ff.ctl1};
				`TCC_IDX_CTL2: nxt_st.prdata = {24'h000000, st_ff.ctl2};
				`TCC_IDX_IRQ_ST: nxt_st.prdata = {30'h00000000, st_ff.irq_st};
				`TCC_IDX_IRQ_MASK: nxt_st.prdata = {30'h00000000, st_ff.irq_mask};
				default: nxt_st.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			st_ff.ch0_val  <= `TCC_VAL_RST;
			st_ff.ch1_val  <= `TCC_VAL_RST;
			st_ff.ch2_val  <= `TCC_VAL_RST;
			st_ff.ctl1     <= tcc_ctl_t'(`TCC_CTL_RST);
			st_ff.ctl2     <= tcc_ctl_t'(`TCC_CTL_RST);
			st_ff.mode     <= tcc_cnt_stop;
			st_ff.up       <= 1'b1;
			st_ff.irq_mask <= `TCC_MASK_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Zero-wait slave; frozen while the enable is low
	assign pready  = ce;
	assign pslverr = psel & penable & ~is_mapped(idx);
	assign prdata  = st_ff.prdata;
	assign irq     = |(st_ff.irq_st & st_ff.irq_mask);
endmodule
`default_nettype wire

// ---- tcc_top_properties.sv ----
// Port-level assertions for tcc_top.
// Assumes a bind to tcc_top; one clock, reset active low.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module tcc_top_properties (
	// Clock, reset and enable
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and interrupt
	input wire logic        ch1_cap_in,
	input wire logic        ch2_cap_in,
	input wire logic        ch1_cmp_out,
	input wire logic        ch2_cmp_out,
	input wire logic        irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_rd_setup;
		psel && !penable && !pwrite && ce;
	endsequence
	sequence s_mask_off;
		psel && penable && pwrite && ce && paddr[11:2] == `TCC_IDX_IRQ_MASK
			&& pwdata[1:0] == 2'h0;
	endsequence

	ready_follows_ce_a: assert property (pready == ce)
		else $error("pready differs from ce");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	err_unmapped_a: assert property (psel && penable && paddr[11:2] == 10'h000 |-> pslverr)
		else $error("no pslverr on unmapped index");
	zero_unmapped_a: assert property (s_rd_setup ##0 paddr[11:2] == 10'h000 |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite && ce) |=> $stable(prdata))
		else $error("prdata moved without read setup");
	rdata_byte_a: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	freeze_out_a: assert property (!ce |=> $stable({ch1_cmp_out, ch2_cmp_out, irq}))
		else $error("outputs moved while ce low");
	irq_masked_a: assert property (s_mask_off |=> !irq)
		else $error("irq high with mask cleared");
	reset_idle_a: assert property ($rose(presetn) |-> !irq && !ch1_cmp_out && !ch2_cmp_out)
		else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ---- tcc_pin_model.sv ----
// Far-side pin model: moves the capture inputs after a lag.
// Assumes requested levels and lag come from the bench.
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
	// Clock
	input  wire logic       pclk,
	// Requests
	input  wire logic [1:0] want,
	input  wire logic [3:0] lag,
	// Capture pins
	output logic      [1:0] pins
);
	logic [3:0] dly_ff = 4'h0;
	initial pins = 2'h0;
	// Slow or prompt answer by lag
	always @(posedge pclk) begin
		if (want == pins) begin
			dly_ff <= 4'h0;
		end else if (dly_ff >= lag) begin
			pins   <= want;
			dly_ff <= 4'h0;
		end else begin
			dly_ff <= dly_ff + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- timer_cc_channels_one_two_tb_top.sv ----
// Bench: registers, compare actions, interrupt and capture.
// Assumes tcc_top, its checker and the pin model alongside.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module timer_cc_channels_one_two_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, ch1_cmp_out, ch2_cmp_out, irq, err;
	logic [1:0]  want = 2'h0;
	logic [1:0]  pins;
	logic [3:0]  lag = 4'h0;
	logic [7:0]  v, lo;
	logic [15:0] exp16, k;
	int          errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [7:0]  run_mode = 8'h02;
	// Action, start count, expected output
	logic [11:0] act_tbl [12] = '{12'h00b, 12'h632, 12'h60b, 12'h80a, 12'h833, 12'h20a,
		12'h40b, 12'ha32, 12'ha0b, 12'hc0a, 12'hc33, 12'h40a};

	tcc_top i_tcc_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ch1_cap_in(pins[0]), .ch2_cap_in(pins[1]),
		.ch1_cmp_out, .ch2_cmp_out, .irq);
	tcc_pin_model i_tcc_pin_model (.pclk, .want, .lag, .pins);

	always #5 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("Compared %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [7:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) errors++;
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [9:0] idx);
		apb(1'b0, idx, 8'h00);
	endtask

	// Eight counts in run_mode, with a freeze inside
	task automatic run_win(input logic [7:0] start);
		wr(`TCC_IDX_CNT_LO, start);
		wr(`TCC_IDX_CNT_HI, 8'h00);
		wr(`TCC_IDX_CNT_CTL, run_mode);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		repeat (5) @(posedge pclk);
		wr(`TCC_IDX_CNT_CTL, 8'hc0);
	endtask

	function automatic logic cap_hit(input logic [1:0] cap, input logic rise);
		return rise ? cap[0] : cap[1];
	endfunction

	initial begin
		void'($urandom(32'h4493));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			rd(i < 2 ? 10'(`TCC_IDX_CTL1 + i) : 10'(`TCC_IDX_CH1_LO + i - 2));
			chk(q, i < 2 ? 32'h40 : 32'h0);
		end
		rd(10'h000);
		chk({q[30:0], err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(10'(`TCC_IDX_CH1_LO + i), v);
			rd(10'(`TCC_IDX_CH1_LO + i));
			chk(q, {24'h0, v});
			if (i == 2) exp16[7:0] = v;
			if (i == 3) exp16[15:8] = v;
		end
		$display("test registers done");
		wr(`TCC_IDX_CH0_LO, 8'h1e);
		wr(`TCC_IDX_CH1_LO, 8'h0a);
		wr(`TCC_IDX_CH1_HI, 8'h00);
		foreach (act_tbl[i]) begin
			wr(`TCC_IDX_CTL1, {2'b01, act_tbl[i][11:9], 3'b100});
			run_win(act_tbl[i][8:1]);
			chk({31'h0, ch1_cmp_out}, {31'h0, act_tbl[i][0]});
		end
		rd(`TCC_IDX_CNT_CTL);
		chk(q, 32'h40);
		wr(`TCC_IDX_CNT_CTL, 8'h80);
		rd(`TCC_IDX_CNT_CTL);
		chk(q, 32'h0);
		$display("test compare done");
		rd(`TCC_IDX_IRQ_ST);
		chk(q, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(`TCC_IDX_IRQ_MASK, 8'h03);
		chk({31'h0, irq}, 32'h1);
		wr(`TCC_IDX_IRQ_ST, 8'h01);
		chk({31'h0, irq}, 32'h0);
		wr(`TCC_IDX_CTL1, 8'h14);
		run_win(8'h05);
		rd(`TCC_IDX_IRQ_ST);
		chk(q, 32'h0);
		wr(`TCC_IDX_IRQ_MASK, 8'h00);
		$display("test interrupt done");
		// Up/down turn at 12: channel 1 sees 10 up and down, channel 2 sees 11
		wr(`TCC_IDX_CH0_LO, 8'h0c);
		wr(`TCC_IDX_CH2_LO, 8'h0b);
		wr(`TCC_IDX_CH2_HI, 8'h00);
		exp16 = 16'h000b;
		wr(`TCC_IDX_CTL1, 8'h64);
		wr(`TCC_IDX_CTL2, 8'h04);
		run_mode = 8'h03;
		run_win(8'h09);
		chk({31'h0, ch1_cmp_out}, 32'h1);
		chk({31'h0, ch2_cmp_out}, 32'h1);
		rd(`TCC_IDX_CNT_LO);
		chk(q, 32'h07);
		// Free run passes the channel 0 value without wrapping
		run_mode = 8'h01;
		run_win(8'h20);
		rd(`TCC_IDX_CNT_LO);
		chk(q, 32'h28);
		$display("test counter modes done");
		for (int m = 0; m < 4; m++) begin
			wr(`TCC_IDX_CTL2, {6'h10, m[1:0]});
			for (int r = 1; r >= 0; r--) begin
				k = 16'($urandom);
				wr(`TCC_IDX_CNT_LO, k[7:0]);
				wr(`TCC_IDX_CNT_HI, k[15:8]);
				lag <= 4'($urandom_range(3));
				want[1] <= r[0];
				repeat (14) @(posedge pclk);
				if (cap_hit(m[1:0], r[0])) exp16 = k;
				rd(`TCC_IDX_CH2_LO);
				lo = q[7:0];
				rd(`TCC_IDX_CH2_HI);
				chk({16'h0, q[7:0], lo}, {16'h0, exp16});
			end
		end
		$display("test capture done");
		final_report();
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			final_report();
		end
	end
endmodule

bind tcc_top tcc_top_properties i_tcc_top_properties (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ch1_cap_in,
	.ch2_cap_in, .ch1_cmp_out, .ch2_cmp_out, .irq);
`default_nettype wire
